//--- pkg/rxed_defines.svh
// constants of the receive energy detection block
`ifndef RXED_DEFINES_SVH
`define RXED_DEFINES_SVH

`define RXED_CLK_MHZ         20
`define RXED_NS_TO_CYC(ns)   (((ns) * `RXED_CLK_MHZ) / 1000)

// first valid power estimate: unit time times sample-rate divider
`define RXED_WARM_UNIT_NS    8000
`define RXED_WARM_UNIT_CYC   `RXED_NS_TO_CYC(`RXED_WARM_UNIT_NS)

// averaging time bases
`define RXED_TB0_NS          2000
`define RXED_TB1_NS          8000
`define RXED_TB2_NS          32000
`define RXED_TB3_NS          128000
`define RXED_TB0_CYC         `RXED_NS_TO_CYC(`RXED_TB0_NS)
`define RXED_TB1_CYC         `RXED_NS_TO_CYC(`RXED_TB1_NS)
`define RXED_TB2_CYC         `RXED_NS_TO_CYC(`RXED_TB2_NS)
`define RXED_TB3_CYC         `RXED_NS_TO_CYC(`RXED_TB3_NS)

// register byte offsets
`define RXED_OFS_BWC         6'h00
`define RXED_OFS_DFE         6'h04
`define RXED_OFS_PWR         6'h08
`define RXED_OFS_EDC         6'h0c
`define RXED_OFS_EDD         6'h10
`define RXED_OFS_EDV         6'h14
`define RXED_OFS_GAIN        6'h18

// reset values
`define RXED_RST_BWC         8'h0b
`define RXED_RST_DFE         8'h01
`define RXED_RST_EDD         8'h05
`define RXED_RST_MODE        2'h0

// field positions
`define RXED_BWC_IFI         5
`define RXED_BWC_IFS         4
`define RXED_BWC_BW_HI       3
`define RXED_DFE_RCUT_LO     5
`define RXED_DFE_SR_HI       3
`define RXED_AVG_DURATION_FACTOR_LO       2
`define RXED_GAIN_FRZC       1
`define RXED_GAIN_FRZS       2

// measurement mode codes
`define RXED_MODE_AUTO       2'h0
`define RXED_MODE_SINGLE     2'h1
`define RXED_MODE_CONT       2'h2
`define RXED_MODE_OFF        2'h3

// power codes
`define RXED_PWR_INVALID     8'h7f
`define RXED_PWR_MAX         8'h04
`define RXED_PWR_MIN         8'h81
`define RXED_PWR_BIAS        8'h7f

`define RXED_RESP_OKAY       2'h0
`define RXED_RESP_SLVERR     2'h2

`endif

//--- pkg/rxed_pkg.sv
// types of the receive energy detection block
package rxed_pkg;
  `include "rxed_defines.svh"

  typedef enum logic [1:0] {
    MODE_AUTO   = `RXED_MODE_AUTO,
    MODE_SINGLE = `RXED_MODE_SINGLE,
    MODE_CONT   = `RXED_MODE_CONT,
    MODE_OFF    = `RXED_MODE_OFF
  } rxed_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_AUTO,
    ST_SW
  } rxed_state_t;

  typedef logic signed [7:0] rxed_pwr_t;
endpackage : rxed_pkg

//--- pkg/rxed_acc_if.sv
// link between the measurement control and the averager
interface rxed_acc_if;
  logic               clear;
  logic               add;
  rxed_pkg::rxed_pwr_t sample;
  rxed_pkg::rxed_pwr_t mean;

  modport owner (output clear, output add, output sample, input mean);
  modport acc   (input clear, input add, input sample, output mean);
endinterface : rxed_acc_if

//--- design/rxed_averager.sv
// running mean of power estimates over one averaging period
`include "rxed_defines.svh"
module rxed_averager #(
  parameter int CNT_W = 16,
  parameter int SUM_W = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  rxed_acc_if.acc  port_acc
);
  import rxed_pkg::*;

  logic [SUM_W-1:0] sum;
  logic [CNT_W-1:0] cnt;
  // biased so the division only ever sees non-negative values
  wire  [7:0]       biased = 8'(port_acc.sample + `RXED_PWR_BIAS);
  wire  [SUM_W+1:0] numer  = {1'b0, sum, 1'b0} + (SUM_W+2)'(cnt);
  wire  [CNT_W:0]   denom  = {cnt, 1'b0};
  wire  [SUM_W+1:0] quot   = numer / (SUM_W+2)'(denom);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum <= '0;
      cnt <= '0;
    end else if (port_acc.clear) begin
      sum <= '0;
      cnt <= '0;
    end else if (port_acc.add && (cnt != '1)) begin
      sum <= sum + SUM_W'(biased);
      cnt <= cnt + 1'b1;
    end
  end

  // mean rounded half up to a whole dB; no samples gives the invalid code
  assign port_acc.mean = (cnt == '0) ? `RXED_PWR_INVALID
                                     : 8'(quot[7:0] - `RXED_PWR_BIAS);
endmodule : rxed_averager

//--- design/rxed_top.sv
// receive energy detection: power estimate, averaging, front-end config
//
// Behaviour
// - power estimate keeps updating in dBm, -127..4, even while gain is frozen
// - power register reads 127 while no valid estimate exists
// - first estimate only after 8 us times sample divider plus gain update
// - measurements in every mode run only in the receive state
// - automatic mode starts averaging when the baseband holds the gain loop
// - automatic run cancelled on frame abort, frame end or leaving receive
// - automatic result held until a later run ends; cancel leaves code 127
// - automatic completion raises no measurement-done event
// - setting gain freeze control starts an automatic measurement
// - clearing gain freeze before period end stops run, result invalid
// - in receive, writing mode 1 starts single, mode 2 continuous
// - single or continuous period end raises done event and stores result
// - single measurement end returns mode field to automatic
// - baseband may start automatic run overwriting an old single result
// - continuous repeats until mode 0 or 3 is written or receive is left
// - continuous results overwrite the result register unread
// - continuous ended by leaving receive restores automatic mode
// - IF shift bit scales IF by 1.25, IF inversion bit flips its sign
// - 4-bit bandwidth field, codes 0x0..0xB, default 0xB
// - mode codes: automatic 0, single 1, continuous 2, disabled 3
// - averaging time is 6-bit factor times 2, 8, 32 or 128 us base
// - power and energy are 8-bit two's complement, -127 to +4
`include "rxed_defines.svh"
module rxed_top (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [5:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [5:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // transceiver state and gain loop
  input  wire logic              rx_active,
  input  wire logic              power_sample_valid,
  input  wire rxed_pkg::rxed_pwr_t power_sample,
  // baseband core
  input  wire logic              bb_gain_hold,
  input  wire logic              bb_frame_abort,
  // outputs
  output logic                   energy_meas_done_event,
  output logic                   gain_freeze_control,
  output logic                   if_inversion,
  output logic                   if_shift,
  output logic [3:0]             rx_filter_bandwidth,
  output logic [2:0]             rx_post_filter_cutoff,
  output logic [3:0]             rx_sample_rate_divider
);
  import rxed_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // decode helpers

  // undefined divider codes fall back to the 4 MHz setting
  function automatic logic [3:0] sr_eff(input logic [3:0] sr);
    case (sr)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'ha: sr_eff = sr;
      default: sr_eff = 4'h1;
    endcase
  endfunction : sr_eff

  function automatic logic [11:0] tb_cycles(input logic [1:0] dtb);
    case (dtb)
      2'h0:    tb_cycles = 12'(`RXED_TB0_CYC);
      2'h1:    tb_cycles = 12'(`RXED_TB1_CYC);
      2'h2:    tb_cycles = 12'(`RXED_TB2_CYC);
      default: tb_cycles = 12'(`RXED_TB3_CYC);
    endcase
  endfunction : tb_cycles

  function automatic logic is_mapped(input logic [5:0] a);
    case (a)
      `RXED_OFS_BWC, `RXED_OFS_DFE, `RXED_OFS_PWR, `RXED_OFS_EDC,
      `RXED_OFS_EDD, `RXED_OFS_EDV, `RXED_OFS_GAIN: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  //////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0]  bwc;
  logic [7:0]  dfe;
  logic [7:0]  edd;
  rxed_mode_t  mode;
  rxed_pwr_t   power_est;
  rxed_pwr_t   result;
  rxed_state_t state;
  logic        freeze_q;
  logic        rx_q;
  logic [7:0]  warm_unit;
  logic [3:0]  warm_mult;
  logic        warm_done;
  logic [11:0] per_tick;
  logic [5:0]  per_df;
  logic [5:0]  aw_addr;
  logic [7:0]  w_byte;
  logic        w_lane0;

  rxed_acc_if acc_link ();

  //////////////////////////////////////////////////////////////////////////
  // bus decode

  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_en    = do_write && w_lane0;
  wire wr_bwc   = wr_en && (aw_addr == `RXED_OFS_BWC);
  wire wr_dfe   = wr_en && (aw_addr == `RXED_OFS_DFE);
  wire wr_edc   = wr_en && (aw_addr == `RXED_OFS_EDC);
  wire wr_edd   = wr_en && (aw_addr == `RXED_OFS_EDD);
  wire wr_gain  = wr_en && (aw_addr == `RXED_OFS_GAIN);
  wire ar_take  = s_axi_arvalid && s_axi_arready;

  //////////////////////////////////////////////////////////////////////////
  // measurement decode

  wire [1:0]  wmode      = w_byte[1:0];
  wire        freeze_any = bb_gain_hold || gain_freeze_control;
  wire        freeze_rise = freeze_any && !freeze_q;
  wire        rx_rise    = rx_active && !rx_q;
  wire [3:0]  sr_use     = sr_eff(dfe[`RXED_DFE_SR_HI:0]);
  wire [5:0]  df_val     = edd[7:`RXED_AVG_DURATION_FACTOR_LO];
  // a zero factor still runs for one time base
  wire [5:0]  df_use     = (df_val == 6'h00) ? 6'h01 : df_val;
  wire [11:0] tb_use     = tb_cycles(edd[1:0]);
  wire        tb_last    = (per_tick == tb_use - 12'h001);
  wire        period_end = (state != ST_IDLE) && tb_last &&
                           (per_df + 6'h01 >= df_use);

  wire sw_start    = wr_edc && rx_active &&
                     ((wmode == `RXED_MODE_SINGLE) || (wmode == `RXED_MODE_CONT));
  wire sw_stop     = wr_edc &&
                     ((wmode == `RXED_MODE_AUTO) || (wmode == `RXED_MODE_OFF));
  wire auto_start  = (state == ST_IDLE) && (mode == MODE_AUTO) &&
                     rx_active && freeze_rise && !sw_start;
  wire auto_cancel = (state == ST_AUTO) &&
                     (bb_frame_abort || !freeze_any || !rx_active);
  wire cont_again  = (state == ST_SW) && period_end && (mode == MODE_CONT) &&
                     rx_active && !sw_stop;
  wire run_clear   = ((state == ST_IDLE) && (sw_start || auto_start)) ||
                     ((state != ST_IDLE) && sw_start) || cont_again;

  // estimate clamped to the documented range
  wire rxed_pwr_t sample_clamped =
         (power_sample > $signed(`RXED_PWR_MAX)) ? rxed_pwr_t'(`RXED_PWR_MAX) :
         (power_sample < $signed(`RXED_PWR_MIN)) ? rxed_pwr_t'(`RXED_PWR_MIN) :
         power_sample;
  wire pwr_take = power_sample_valid && warm_done && rx_active;

  assign acc_link.clear  = run_clear;
  assign acc_link.add    = (state != ST_IDLE) && pwr_take && !run_clear;
  assign acc_link.sample = sample_clamped;

  rxed_averager u_avg (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .port_acc (acc_link.acc)
  );

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RXED_RESP_OKAY;
      aw_addr       <= 6'h00;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr) ? `RXED_RESP_OKAY : `RXED_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic [7:0] rd_byte;
  always_comb begin
    case (s_axi_araddr)
      `RXED_OFS_BWC:  rd_byte = bwc;
      `RXED_OFS_DFE:  rd_byte = dfe;
      `RXED_OFS_PWR:  rd_byte = power_est;
      `RXED_OFS_EDC:  rd_byte = {6'h00, mode};
      `RXED_OFS_EDD:  rd_byte = edd;
      `RXED_OFS_EDV:  rd_byte = result;
      `RXED_OFS_GAIN: rd_byte = {5'h00, freeze_any, gain_freeze_control, 1'b0};
      default:        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RXED_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= is_mapped(s_axi_araddr) ? `RXED_RESP_OKAY : `RXED_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // front-end configuration

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bwc                 <= `RXED_RST_BWC;
      dfe                 <= `RXED_RST_DFE;
      edd                 <= `RXED_RST_EDD;
      gain_freeze_control <= 1'b0;
    end else begin
      // bits 7:6 of the bandwidth byte are reserved
      if (wr_bwc) bwc <= {2'b00, w_byte[5:0]};
      // bit 4 of the frontend byte is read-only zero
      if (wr_dfe) dfe <= {w_byte[7:5], 1'b0, w_byte[3:0]};
      if (wr_edd) edd <= w_byte;
      if (wr_gain) gain_freeze_control <= w_byte[`RXED_GAIN_FRZC];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if_inversion           <= 1'b0;
      if_shift               <= 1'b0;
      rx_filter_bandwidth    <= 4'hb;
      rx_post_filter_cutoff  <= 3'h0;
      rx_sample_rate_divider <= 4'h1;
    end else begin
      if_inversion           <= bwc[`RXED_BWC_IFI];
      if_shift               <= bwc[`RXED_BWC_IFS];
      rx_filter_bandwidth    <= bwc[`RXED_BWC_BW_HI:0];
      rx_post_filter_cutoff  <= dfe[7:`RXED_DFE_RCUT_LO];
      rx_sample_rate_divider <= sr_use;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power estimate with start-up hold-off

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_q      <= 1'b0;
      warm_unit <= 8'h00;
      warm_mult <= 4'h0;
      warm_done <= 1'b0;
      power_est <= `RXED_PWR_INVALID;
    end else begin
      rx_q <= rx_active;
      if (!rx_active || rx_rise) begin
        warm_unit <= 8'h00;
        warm_mult <= 4'h0;
        warm_done <= 1'b0;
        power_est <= `RXED_PWR_INVALID;
      end else begin
        if (!warm_done) begin
          if (warm_unit == 8'(`RXED_WARM_UNIT_CYC - 1)) begin
            warm_unit <= 8'h00;
            warm_mult <= warm_mult + 4'h1;
            if (warm_mult + 4'h1 >= sr_use) warm_done <= 1'b1;
          end else begin
            warm_unit <= warm_unit + 8'h01;
          end
        end
        // gain freeze does not gate the estimate
        if (pwr_take) power_est <= sample_clamped;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // averaging period timer

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_tick <= 12'h000;
      per_df   <= 6'h00;
    end else if (run_clear || (state == ST_IDLE)) begin
      per_tick <= 12'h000;
      per_df   <= 6'h00;
    end else if (tb_last) begin
      per_tick <= 12'h000;
      per_df   <= per_df + 6'h01;
    end else begin
      per_tick <= per_tick + 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // measurement control

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state                  <= ST_IDLE;
      mode                   <= rxed_mode_t'(`RXED_RST_MODE);
      result                 <= `RXED_PWR_INVALID;
      freeze_q               <= 1'b0;
      energy_meas_done_event <= 1'b0;
    end else begin
      freeze_q               <= freeze_any;
      energy_meas_done_event <= 1'b0;
      if (wr_edc) mode <= rxed_mode_t'(wmode);
      case (state)
        ST_IDLE: begin
          if (sw_start) state <= ST_SW;
          else if (auto_start) state <= ST_AUTO;
        end
        ST_AUTO: begin
          if (sw_start) begin
            state <= ST_SW;
          end else if (auto_cancel) begin
            state  <= ST_IDLE;
            result <= `RXED_PWR_INVALID;
          end else if (period_end) begin
            // kept until a later run replaces it; no event here
            state  <= ST_IDLE;
            result <= acc_link.mean;
          end
        end
        ST_SW: begin
          if (sw_start) begin
            state <= ST_SW;
          end else if (!rx_active) begin
            state <= ST_IDLE;
            if (mode == MODE_CONT) mode <= MODE_AUTO;
          end else if (sw_stop) begin
            state <= ST_IDLE;
          end else if (period_end) begin
            result                 <= acc_link.mean;
            energy_meas_done_event <= 1'b1;
            if (mode != MODE_CONT) begin
              state <= ST_IDLE;
              mode  <= MODE_AUTO;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : rxed_top

//--- verification/rxed_props.sv
// port assertions of the energy detection block
module rxed_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        rx_active,
  input wire logic        energy_meas_done_event,
  input wire logic        gain_freeze_control,
  input wire logic        if_inversion,
  input wire logic        if_shift,
  input wire logic [3:0]  rx_filter_bandwidth,
  input wire logic [2:0]  rx_post_filter_cutoff,
  input wire logic [3:0]  rx_sample_rate_divider
);
  wire logic [12:0] cfg = {if_inversion, if_shift, rx_filter_bandwidth,
                           rx_post_filter_cutoff, rx_sample_rate_divider};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  chk_done_spacing: assert property (energy_meas_done_event |=> !energy_meas_done_event [*8])
    else $error("done pulses too close");
  chk_done_in_rx: assert property (energy_meas_done_event |-> $past(rx_active))
    else $error("done outside receive");
  chk_cfg_on_write: assert property (!$stable(cfg) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("config moved without write");
  chk_freeze_on_write: assert property (!$stable(gain_freeze_control) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("freeze moved without write");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : rxed_props

bind rxed_top rxed_props u_props (.*);

//--- verification/rxed_gain_model.sv
// gain loop model: one power estimate every 8 cycles while receiving
module rxed_gain_model (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                rx_active,
  input  wire rxed_pkg::rxed_pwr_t level,
  output logic                     valid,
  output rxed_pkg::rxed_pwr_t      sample
);
  import rxed_pkg::*;
  logic [2:0] tick;
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_active) begin
      tick  <= 3'h0;
      valid <= 1'b0;
    end else begin
      tick  <= tick + 3'h1;
      valid <= (tick == 3'h7);
    end
    // level stays within -127..4; in the cycle after each estimate the bus shows junk
    sample <= (!aresetn) ? 8'h00 : (valid ? ~sample : level);
  end
endmodule : rxed_gain_model

//--- verification/test_rx_energy_detection.sv
// self-checking bench of the energy detection block
module test_rx_energy_detection;
  timeunit 1ns;
  timeprecision 1ns;
  import rxed_pkg::*;
  typedef struct {logic [5:0] a; logic w; logic [7:0] d; logic [7:0] e;} rxed_row_t;
  logic        aclk = 0, aresetn = 0, rx_active = 0, bb_frame_abort = 0;
  logic        bb_gain_hold = 0;
  logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, rx_filter_bandwidth, rx_sample_rate_divider;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, rr;
  logic        power_sample_valid, energy_meas_done_event, gain_freeze_control;
  logic        if_inversion, if_shift;
  logic [2:0]  rx_post_filter_cutoff;
  logic [7:0]  rd;
  rxed_pwr_t   power_sample, level = -50;
  int          n_errors = 0, check_count = 0, n_done = 0, k;
  rxed_row_t   rows [8] = '{'{6'h00, 0, 8'h00, 8'h0b}, '{6'h04, 0, 8'h00, 8'h01},
    '{6'h08, 0, 8'h00, 8'h7f}, '{6'h14, 0, 8'h00, 8'h7f}, '{6'h10, 0, 8'h00, 8'h05},
    '{6'h0c, 0, 8'h00, 8'h00}, '{6'h00, 1, 8'h3a, 8'h3a},
    '{6'h04, 1, 8'h31, 8'h21}}; // bit 4 of frontend config is read-only
  rxed_top dut_u (.*);
  rxed_gain_model gain_u (.aclk(aclk), .aresetn(aresetn), .rx_active(rx_active),
    .level(level), .valid(power_sample_valid), .sample(power_sample));
  always #25 aclk = ~aclk;
  always @(posedge aclk) if (energy_meas_done_event === 1'b1) n_done <= n_done + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      // late ready makes the slave hold its response for a cycle
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    if (!(s_axi_bvalid && s_axi_bready)) n_errors++;
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rc(input string nm, input logic [5:0] a, input logic [7:0] e);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    if (!(s_axi_rvalid && s_axi_rready)) n_errors++;
    rd = s_axi_rdata[7:0];
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(nm, e, rd);
  endtask : rc
  task automatic wait_done(input int kk);
    int n;
    n = 0;
    while (n_done < kk && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    if (n_done < kk) n_errors++;
  endtask : wait_done
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rc("register", rows[i].a, rows[i].e);
    end
    chk("bw out", 8'h3a, {2'b00, if_inversion, if_shift, rx_filter_bandwidth});
    chk("dfe out", 8'h21, {rx_post_filter_cutoff, 1'b0, rx_sample_rate_divider});
    wr(6'h10, 8'h04);
    wr(6'h1c, 8'h55);
    chk("unmapped", 8'h02, {6'h0, rs});
    rc("unmapped rd", 6'h1c, 8'h00);
    chk("unmapped rresp", 8'h02, {6'h0, rr});
    s_axi_wstrb <= 4'h0;
    wr(6'h00, 8'h11);
    s_axi_wstrb <= 4'hf;
    rc("no strobe", 6'h00, 8'h3a);
    chk("rresp okay", 8'h00, {6'h0, rr});
    $display("end registers");
    rx_active <= 1'b1;
    repeat (140) @(posedge aclk);
    rc("pwr early", 6'h08, 8'h7f);
    repeat (40) @(posedge aclk);
    rc("pwr", 6'h08, 8'hce);
    wr(6'h18, 8'h02);
    repeat (60) @(posedge aclk);
    rc("auto", 6'h14, 8'hce);
    level <= -20;
    repeat (20) @(posedge aclk);
    rc("pwr frozen", 6'h08, 8'hec);
    chk("no auto done", 8'h00, n_done[7:0]);
    wr(6'h18, 8'h00);
    wr(6'h18, 8'h02);
    repeat (10) @(posedge aclk);
    wr(6'h18, 8'h00);
    repeat (50) @(posedge aclk);
    rc("cancel", 6'h14, 8'h7f);
    $display("end power and auto");
    wr(6'h0c, 8'h01);
    wait_done(1);
    rc("single", 6'h14, 8'hec);
    rc("mode back", 6'h0c, 8'h00);
    chk("one done", 8'h01, n_done[7:0]);
    wr(6'h0c, 8'h02);
    wait_done(3);
    level <= -70;
    wait_done(5);
    rc("cont", 6'h14, 8'hba);
    rx_active <= 1'b0;
    repeat (3) @(posedge aclk);
    rc("mode rx left", 6'h0c, 8'h00);
    rc("pwr off", 6'h08, 8'h7f);
    k = n_done;
    repeat (100) @(posedge aclk);
    chk("no run off rx", k[7:0], n_done[7:0]);
    $display("end single and continuous");
    rx_active <= 1'b1;
    level <= -50;
    repeat (200) @(posedge aclk);
    bb_gain_hold <= 1'b1;
    repeat (60) @(posedge aclk);
    rc("bb auto", 6'h14, 8'hce);
    rc("freeze status", 6'h18, 8'h04);
    bb_gain_hold <= 1'b0;
    @(posedge aclk);
    bb_gain_hold <= 1'b1;
    repeat (10) @(posedge aclk);
    bb_frame_abort <= 1'b1;
    @(posedge aclk);
    bb_frame_abort <= 1'b0;
    repeat (50) @(posedge aclk);
    rc("abort", 6'h14, 8'h7f);
    wr(6'h0c, 8'h03);
    bb_gain_hold <= 1'b0;
    @(posedge aclk);
    bb_gain_hold <= 1'b1;
    repeat (60) @(posedge aclk);
    rc("disabled", 6'h14, 8'h7f);
    $display("end baseband");
    conclude();
  end
  initial begin
    // whole run is near 1100 cycles
    repeat (20000) @(posedge aclk);
    n_errors++;
    conclude();
  end
endmodule : test_rx_energy_detection
